// ==== rtl/idw_pkg.sv ====
package idw_pkg;

  // Avalon register map (byte addresses)
  localparam logic [7:0] ADDR_UDMA_CFG = 8'h00;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h04;
  localparam logic [7:0] ADDR_ERASE_TIME = 8'h08;
  localparam logic [7:0] ADDR_APM_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_SEC_CTRL = 8'h10;
  localparam logic [7:0] ADDR_POWER_CFG = 8'h14;
  localparam logic [7:0] ADDR_ADV_CAP = 8'h18;
  localparam logic [7:0] ADDR_SEC_CMD = 8'h1C;
  localparam logic [7:0] ADDR_WORD88 = 8'h20;
  localparam logic [7:0] ADDR_WORD89 = 8'h24;
  localparam logic [7:0] ADDR_WORD90 = 8'h28;
  localparam logic [7:0] ADDR_WORD91 = 8'h2C;
  localparam logic [7:0] ADDR_WORD128 = 8'h30;
  localparam logic [7:0] ADDR_WORD160 = 8'h34;
  localparam logic [7:0] ADDR_WORD162 = 8'h38;
  localparam logic [7:0] ADDR_WORD163 = 8'h3C;

  // Identify word numbers on the word port
  localparam logic [7:0] WNUM_88 = 8'h58;
  localparam logic [7:0] WNUM_89 = 8'h59;
  localparam logic [7:0] WNUM_90 = 8'h5A;
  localparam logic [7:0] WNUM_91 = 8'h5B;
  localparam logic [7:0] WNUM_128 = 8'h80;
  localparam logic [7:0] WNUM_160 = 8'hA0;
  localparam logic [7:0] WNUM_162 = 8'hA2;
  localparam logic [7:0] WNUM_163 = 8'hA3;

  // Mode select command kinds (MODE_SEL bits 5:4)
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_UDMA = 2'h1;
  localparam logic [1:0] SEL_MDMA = 2'h2;

  // Advanced mode codes
  localparam logic [2:0] ADV_LEGACY = 3'h0;
  localparam logic [2:0] ADV_MAX = 3'h2;

  // Security command codes (SEC_CMD bits 1:0)
  localparam logic [1:0] SCMD_FAIL = 2'h1;
  localparam logic [1:0] SCMD_UNLOCK = 2'h2;
  localparam logic [1:0] SCMD_ERASE = 2'h3;

  localparam logic [7:0] SEC_ATTEMPTS = 8'h05;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK = 3'b010,
    ST_HOLD = 3'b100
  } bus_state_e;

endpackage : idw_pkg

// ==== rtl/identify_word_formatter.sv ====
`timescale 1ns/100ps
// Contract
// - At most one DMA mode selected; Ultra and Multiword selections exclude each other.
// - Word 88 bits 14..8 flag selected Ultra DMA mode 6..0.
// - Word 88 bits 6..0 flag supported modes; higher support implies all lower.
// - Word 88 is provided whenever any Ultra DMA mode is supported.
// - Word 89: normal erase time code, 0 unspecified, 1-254 x2 minutes, 255 longer.
// - Word 90: enhanced erase time code using the same scheme.
// - Word 91 low byte holds current power management level.
// - Word 128 bit 8 is one for maximum security level when enabled.
// - Word 128 bit 5 flags enhanced erase support.
// - Word 128 bit 4 flags expired attempts; unlock and erase aborted until reset.
// - Word 128 bit 3 flags frozen, bit 2 flags locked.
// - Word 128 bit 1 flags security enabled, bit 0 flags support.
// - Word 160 given for power mode 1; bit 15 valid, bit 14 zero.
// - Word 160 bit 13 lacks level 1 commands, bit 12 commands disabled.
// - Word 160 bits 11..0 hold maximum current in mA.
// - Word 162 bit 0 flags key scheme support; bits 15..1 reserved.
// - Word 163 bits 2..0 give maximum advanced PIO mode code.
// - Word 163 bits 5..3 give maximum advanced Multiword DMA code.
// - Word 163 bits 8..6 give selected advanced PIO code.
// - Word 163 bits 11..9 give selected advanced Multiword DMA code.
// - Word 163 bits 15..12 reserved, carry nothing.
module identify_word_formatter
  import idw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Identify word port
  input wire logic [7:0] word_num,
  output logic [15:0] word_data,
  output logic word_valid,
  // Security command result
  output logic sec_cmd_abort
);

  typedef struct packed {
    bus_state_e bst;
    logic [31:0] rdata;
    logic [6:0] udma_sup;
    logic [6:0] udma_sel;
    logic [2:0] mdma_sel;
    logic [2:0] pio_sel;
    logic [7:0] erase_norm;
    logic [7:0] erase_enh;
    logic [7:0] apm;
    logic sec_sup;
    logic sec_en;
    logic sec_max;
    logic enh_sup;
    logic frozen;
    logic locked;
    logic expired;
    logic [7:0] fail_cnt;
    logic abort;
    logic pwr_valid;
    logic no_level1_commands;
    logic level1_commands_disabled;
    logic [11:0] max_ma;
    logic key_sup;
    logic [2:0] pio_max;
    logic [2:0] mdma_max;
    logic [15:0] wdata;
    logic wvalid;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic [15:0] w88;
  logic [15:0] w89;
  logic [15:0] w90;
  logic [15:0] w91;
  logic [15:0] w128;
  logic [15:0] w160;
  logic [15:0] w162;
  logic [15:0] w163;
  logic [6:0] sup_fill;
  logic [6:0] sel_onehot;
  logic [2:0] sel_mode;
  logic [1:0] sel_kind;
  logic [2:0] sel_adv;
  logic [31:0] rd_mux;
  logic [15:0] wd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Word assembly

  always_comb begin
    sup_fill = st_reg.udma_sup;
    for (int i = 5; i >= 0; i--) begin
      sup_fill[i] = sup_fill[i] | sup_fill[i + 1];
    end
  end

  assign w88 = {1'b0, st_reg.udma_sel, 1'b0, sup_fill};
  assign w89 = {8'h00, st_reg.erase_norm};
  assign w90 = {8'h00, st_reg.erase_enh};
  assign w91 = {8'h00, st_reg.apm};
  assign w128 = {7'h00, st_reg.sec_en & st_reg.sec_max, 2'h0, st_reg.enh_sup,
    st_reg.expired, st_reg.frozen, st_reg.locked, st_reg.sec_en, st_reg.sec_sup};
  assign w160 = st_reg.pwr_valid ? {1'b1, 1'b0, st_reg.no_level1_commands,
    st_reg.level1_commands_disabled, st_reg.max_ma} : 16'h0000;
  assign w162 = {15'h0000, st_reg.key_sup};
  assign w163 = {4'h0, st_reg.mdma_sel, st_reg.pio_sel,
    st_reg.mdma_max, st_reg.pio_max};

  always_comb begin
    unique case (word_num)
      WNUM_88: wd_mux = w88;
      WNUM_89: wd_mux = w89;
      WNUM_90: wd_mux = w90;
      WNUM_91: wd_mux = w91;
      WNUM_128: wd_mux = w128;
      WNUM_160: wd_mux = w160;
      WNUM_162: wd_mux = w162;
      WNUM_163: wd_mux = w163;
      default: wd_mux = 16'h0000;
    endcase
  end

  always_comb begin
    unique case (address)
      ADDR_UDMA_CFG: rd_mux = {25'h0, st_reg.udma_sup};
      ADDR_MODE_SEL: rd_mux = {26'h0, sel_kind_rd(st_reg), 1'b0, sel_mode_rd(st_reg)};
      ADDR_ERASE_TIME: rd_mux = {16'h0, st_reg.erase_enh, st_reg.erase_norm};
      ADDR_APM_LEVEL: rd_mux = {24'h0, st_reg.apm};
      ADDR_SEC_CTRL: rd_mux = {16'h0, st_reg.fail_cnt, 1'b0, st_reg.expired,
        st_reg.locked, st_reg.frozen, st_reg.enh_sup, st_reg.sec_max,
        st_reg.sec_en, st_reg.sec_sup};
      ADDR_POWER_CFG: rd_mux = {17'h0, st_reg.pwr_valid, st_reg.no_level1_commands,
        st_reg.level1_commands_disabled, st_reg.max_ma};
      ADDR_ADV_CAP: rd_mux = {25'h0, st_reg.key_sup, st_reg.mdma_max, st_reg.pio_max};
      ADDR_SEC_CMD: rd_mux = {31'h0, st_reg.abort};
      ADDR_WORD88: rd_mux = {16'h0, w88};
      ADDR_WORD89: rd_mux = {16'h0, w89};
      ADDR_WORD90: rd_mux = {16'h0, w90};
      ADDR_WORD91: rd_mux = {16'h0, w91};
      ADDR_WORD128: rd_mux = {16'h0, w128};
      ADDR_WORD160: rd_mux = {16'h0, w160};
      ADDR_WORD162: rd_mux = {16'h0, w162};
      ADDR_WORD163: rd_mux = {16'h0, w163};
      default: rd_mux = ZERO_WORD;
    endcase
  end

  function automatic logic [1:0] sel_kind_rd(input state_s s);
    if (|s.udma_sel) begin
      sel_kind_rd = SEL_UDMA;
    end else if (s.mdma_sel != ADV_LEGACY) begin
      sel_kind_rd = SEL_MDMA;
    end else begin
      sel_kind_rd = SEL_NONE;
    end
  endfunction : sel_kind_rd

  function automatic logic [2:0] sel_mode_rd(input state_s s);
    sel_mode_rd = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (s.udma_sel[i]) begin
        sel_mode_rd = 3'(i);
      end
    end
    if (!(|s.udma_sel)) begin
      sel_mode_rd = s.mdma_sel;
    end
  endfunction : sel_mode_rd

  ////////////////////////////////////////////////////////////////////////////
  // Mode select decode

  assign sel_kind = writedata[5:4];
  assign sel_mode = writedata[2:0];
  assign sel_adv = (writedata[10:8] > ADV_MAX) ? ADV_LEGACY : writedata[10:8];
  assign sel_onehot = (sel_mode < 3'h7) ? 7'(7'h01 << sel_mode) : 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;
    st_next.wdata = wd_mux;
    st_next.wvalid = 1'b1;
    unique case (st_reg.bst)
      ST_IDLE: begin
        if (read || write) begin
          st_next.bst = ST_ACK;
          st_next.rdata = rd_mux;
        end
      end
      ST_ACK: begin
        st_next.bst = ST_HOLD;
        if (write && byteenable[0]) begin
          unique case (address)
            ADDR_UDMA_CFG: st_next.udma_sup = writedata[6:0];
            ADDR_MODE_SEL: begin
              st_next.pio_sel = sel_adv;
              if (sel_kind == SEL_UDMA && sup_fill[sel_mode[2:0] < 3'h7 ? sel_mode : 3'h0]
                  && sel_mode < 3'h7) begin
                st_next.udma_sel = sel_onehot;
                st_next.mdma_sel = ADV_LEGACY;
              end else if (sel_kind == SEL_MDMA) begin
                st_next.udma_sel = 7'h00;
                st_next.mdma_sel = (sel_mode > ADV_MAX) ? ADV_LEGACY : sel_mode;
              end else begin
                st_next.udma_sel = 7'h00;
                st_next.mdma_sel = ADV_LEGACY;
              end
            end
            ADDR_ERASE_TIME: begin
              st_next.erase_norm = writedata[7:0];
              if (byteenable[1]) begin
                st_next.erase_enh = writedata[15:8];
              end
            end
            ADDR_APM_LEVEL: st_next.apm = writedata[7:0];
            ADDR_SEC_CTRL: begin
              st_next.sec_sup = writedata[0];
              st_next.sec_en = writedata[1] & writedata[0];
              st_next.sec_max = writedata[2];
              st_next.enh_sup = writedata[3];
              st_next.frozen = writedata[4];
              st_next.locked = writedata[5];
            end
            ADDR_POWER_CFG: begin
              st_next.max_ma = writedata[11:0];
              st_next.level1_commands_disabled = writedata[12];
              st_next.no_level1_commands = writedata[13];
              st_next.pwr_valid = writedata[14];
            end
            ADDR_ADV_CAP: begin
              st_next.pio_max = (writedata[2:0] > ADV_MAX) ? ADV_LEGACY : writedata[2:0];
              st_next.mdma_max = (writedata[5:3] > ADV_MAX) ? ADV_LEGACY : writedata[5:3];
              st_next.key_sup = writedata[6];
            end
            ADDR_SEC_CMD: begin
              st_next.abort = 1'b0;
              if (writedata[1:0] == SCMD_FAIL && !st_reg.expired) begin
                st_next.fail_cnt = st_reg.fail_cnt + 8'h01;
                if (st_reg.fail_cnt + 8'h01 >= SEC_ATTEMPTS) begin
                  st_next.expired = 1'b1;
                end
              end else if ((writedata[1:0] == SCMD_UNLOCK || writedata[1:0] == SCMD_ERASE)
                  && st_reg.expired) begin
                st_next.abort = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_HOLD: begin
        if (!read && !write) begin
          st_next.bst = ST_IDLE;
        end
      end
      default: st_next.bst = ST_IDLE;
    endcase
    if (!rst_n) begin
      st_next = '0;
      st_next.bst = ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign waitrequest = (st_reg.bst != ST_ACK);
  assign readdata = st_reg.rdata;
  assign word_data = st_reg.wdata;
  assign word_valid = st_reg.wvalid;
  assign sec_cmd_abort = st_reg.abort;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_dma_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
    !((|st_reg.udma_sel) && st_reg.mdma_sel != ADV_LEGACY) && $onehot0(st_reg.udma_sel))
    else $error("Two DMA modes selected");
  a_udma_sel_map: assert property (@(posedge mclk) disable iff (!rst_n)
    w88[14:8] == st_reg.udma_sel)
    else $error("Word 88 select field wrong");
  a_sup_fill: assert property (@(posedge mclk) disable iff (!rst_n)
    ((w88[6:0] + 7'h01) & w88[6:0]) == 7'h00)
    else $error("Word 88 support not contiguous");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    w88[15] == 1'b0 && w88[7] == 1'b0 && w163[15:12] == 4'h0 && w160[14] == 1'b0)
    else $error("Reserved bit set");
  a_expire_abort: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.bst == ST_ACK && write && address == ADDR_SEC_CMD && byteenable[0]
      && st_reg.expired && writedata[1] |=> sec_cmd_abort)
    else $error("Expired unlock not aborted");
  a_expire_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.expired |=> st_reg.expired && w128[4])
    else $error("Expire flag dropped");
  a_level_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    w128[8] |-> w128[1])
    else $error("Maximum level without enable");
  a_power_valid: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_reg.pwr_valid |-> w160 == 16'h0000)
    else $error("Power word without valid");
  a_mode_atomic: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.bst == ST_ACK && write && address == ADDR_MODE_SEL && byteenable[0]
      && writedata[5:4] == SEL_MDMA |=> w88[14:8] == 7'h00)
    else $error("Ultra select not cleared");
  a_ack_one: assert property (@(posedge mclk) disable iff (!rst_n)
    !waitrequest |=> waitrequest)
    else $error("Waitrequest low twice");

  ////////////////////////////////////////////////////////////////////////////
  // Word content checks

  a_word_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
    !((|w88[14:8]) && w163[11:9] != ADV_LEGACY))
    else $error("Ultra and Multiword both selected");
  a_udma_clears_mdma: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.bst == ST_ACK && write && address == ADDR_MODE_SEL && byteenable[0]
      && writedata[5:4] == SEL_UDMA |=> w163[11:9] == ADV_LEGACY)
    else $error("Multiword select not cleared");
  a_adv_max_code: assert property (@(posedge mclk) disable iff (!rst_n)
    w163[2:0] <= ADV_MAX && w163[5:3] <= ADV_MAX)
    else $error("Reserved advanced support code");
  a_adv_sel_code: assert property (@(posedge mclk) disable iff (!rst_n)
    w163[8:6] <= ADV_MAX && w163[11:9] <= ADV_MAX)
    else $error("Reserved advanced select code");
  a_key_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    w162[15:1] == 15'h0000)
    else $error("Key scheme reserved bit set");
  a_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    w89[15:8] == 8'h00 && w90[15:8] == 8'h00 && w91[15:8] == 8'h00)
    else $error("Upper byte of byte word set");
  a_erase_load: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.bst == ST_ACK && write && address == ADDR_ERASE_TIME && byteenable[0]
      |=> w89[7:0] == $past(writedata[7:0]))
    else $error("Erase time not loaded");
  a_apm_load: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.bst == ST_ACK && write && address == ADDR_APM_LEVEL && byteenable[0]
      |=> w91[7:0] == $past(writedata[7:0]))
    else $error("Power management level not loaded");
  a_expire_count: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.expired |-> st_reg.fail_cnt == SEC_ATTEMPTS)
    else $error("Expired before attempt limit");
  a_abort_expired: assert property (@(posedge mclk) disable iff (!rst_n)
    sec_cmd_abort |-> st_reg.expired)
    else $error("Abort without expiry");
  a_word_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> word_data == $past(wd_mux))
    else $error("Word port lags selected word");
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.bst == ST_HOLD |-> $stable(readdata))
    else $error("Read data moved after answer");

  c_udma_pick: cover property (@(posedge mclk) disable iff (!rst_n) |st_reg.udma_sel);
  c_mdma_pick: cover property (@(posedge mclk) disable iff (!rst_n)
    st_reg.mdma_sel != ADV_LEGACY);
  c_expired: cover property (@(posedge mclk) disable iff (!rst_n) sec_cmd_abort);
  c_expire_set: cover property (@(posedge mclk) disable iff (!rst_n) $rose(st_reg.expired));
  c_power_desc: cover property (@(posedge mclk) disable iff (!rst_n) w160[15]);

endmodule : identify_word_formatter

// ==== sim/ata_host_model.sv ====
`timescale 1ns/100ps
module ata_host_model (
  // Clock
  input wire logic mclk,
  // Identify word port
  output logic [7:0] word_num,
  input wire logic [15:0] word_data
);
  initial word_num = 8'h00;
  ////////////////////////////////////////
  // Host puts a word number out, takes the word two edges later
  task automatic fetch(input logic [7:0] num, output logic [15:0] val);
    @(posedge mclk);
    word_num <= num;
    @(posedge mclk);
    @(posedge mclk);
    val = word_data;
  endtask : fetch
endmodule : ata_host_model

// ==== sim/identify_word_formatter_tb.sv ====
`timescale 1ns/100ps
module identify_word_formatter_tb
  import idw_pkg::*;
;
  logic mclk, rst_n, read, write, waitrequest, word_valid, sec_cmd_abort;
  logic [7:0] address, word_num;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [15:0] word_data;
  int errors, n_checks;
  logic [31:0] sc_in [6] = '{32'h01, 32'h03, 32'h07, 32'h08, 32'h10, 32'h20};
  logic [15:0] sc_out [6] = '{16'h0001, 16'h0003, 16'h0103, 16'h0020, 16'h0008, 16'h0004};

  identify_word_formatter i_identify_word_formatter (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .word_num(word_num), .word_data(word_data),
    .word_valid(word_valid), .sec_cmd_abort(sec_cmd_abort)
  );
  ata_host_model i_ata_host_model (.mclk(mclk), .word_num(word_num), .word_data(word_data));

  ////////////////////////////////////////
  // Clock, watchdog, verdict
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////
  // Access tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rd_chk
  task wp_chk(input logic [7:0] num, input logic [15:0] exp);
    logic [15:0] v;
    i_ata_host_model.fetch(num, v);
    check({16'h0000, v}, {16'h0000, exp});
  endtask : wp_chk
  task cmd_chk(input logic [1:0] c, input logic ab, input logic [31:0] w);
    wr(ADDR_SEC_CMD, {30'h0000_0000, c});
    rd_chk(ADDR_WORD128, w);
    check({31'h0000_0000, sec_cmd_abort}, {31'h0000_0000, ab});
  endtask : cmd_chk
  task do_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    check({31'h0000_0000, word_valid}, 32'h0000_0001);
  endtask : do_reset

  ////////////////////////////////////////
  // Tests
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    do_reset();
    rd_chk(ADDR_WORD88, 32'h0000_0000);
    wr(ADDR_UDMA_CFG, 32'h0000_007F);
    wr(ADDR_ADV_CAP, 32'h0000_0052);
    for (int m = 0; m < 7; m++) begin
      wr(ADDR_MODE_SEL, 32'h0000_0010 | 32'(m));
      rd_chk(ADDR_WORD88, (32'h0000_0100 << m) | 32'h0000_007F);
    end
    wp_chk(WNUM_88, 16'h407F);
    wr(ADDR_MODE_SEL, 32'h0000_0122);
    rd_chk(ADDR_WORD88, 32'h0000_007F);
    rd_chk(ADDR_MODE_SEL, 32'h0000_0022);
    rd_chk(ADDR_WORD163, 32'h0000_0452);
    wr(ADDR_MODE_SEL, 32'h0000_0213);
    rd_chk(ADDR_WORD163, 32'h0000_0092);
    rd_chk(ADDR_MODE_SEL, 32'h0000_0013);
    wp_chk(WNUM_88, 16'h087F);
    wp_chk(WNUM_162, 16'h0001);
    wr(ADDR_UDMA_CFG, 32'h0000_0007);
    wr(ADDR_MODE_SEL, 32'h0000_0015);
    rd_chk(ADDR_WORD88, 32'h0000_0007);
    wr(ADDR_UDMA_CFG, 32'h0000_0020);
    rd_chk(ADDR_UDMA_CFG, 32'h0000_0020);
    rd_chk(ADDR_WORD88, 32'h0000_003F);
    wr(ADDR_ERASE_TIME, 32'h0000_FF01);
    wp_chk(WNUM_89, 16'h0001);
    wp_chk(WNUM_90, 16'h00FF);
    wr(ADDR_ERASE_TIME, 32'h0000_00FE);
    rd_chk(ADDR_WORD89, 32'h0000_00FE);
    rd_chk(ADDR_WORD90, 32'h0000_0000);
    wr(ADDR_APM_LEVEL, 32'h0000_00A5);
    wp_chk(WNUM_91, 16'h00A5);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_SEC_CTRL, sc_in[i]);
      wp_chk(WNUM_128, sc_out[i]);
    end
    wr(ADDR_POWER_CFG, 32'h0000_73E8);
    wp_chk(WNUM_160, 16'hB3E8);
    wr(ADDR_POWER_CFG, 32'h0000_4FFF);
    wp_chk(WNUM_160, 16'h8FFF);
    wr(ADDR_POWER_CFG, 32'h0000_33E8);
    rd_chk(ADDR_WORD160, 32'h0000_0000);
    wr(ADDR_SEC_CTRL, 32'h0000_0001);
    repeat (4) cmd_chk(SCMD_FAIL, 1'b0, 32'h0000_0001);
    cmd_chk(SCMD_UNLOCK, 1'b0, 32'h0000_0001);
    cmd_chk(SCMD_FAIL, 1'b0, 32'h0000_0011);
    cmd_chk(SCMD_UNLOCK, 1'b1, 32'h0000_0011);
    cmd_chk(SCMD_FAIL, 1'b0, 32'h0000_0011);
    cmd_chk(SCMD_ERASE, 1'b1, 32'h0000_0011);
    rd_chk(ADDR_SEC_CTRL, 32'h0000_0541);
    rd_chk(8'h40, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000);
    wp_chk(8'h00, 16'h0000);
    wr(ADDR_ADV_CAP, 32'h0000_003F);
    rd_chk(ADDR_WORD163, 32'h0000_0000);
    wp_chk(WNUM_162, 16'h0000);
    do_reset();
    rd_chk(ADDR_WORD128, 32'h0000_0000);
    print_verdict();
  end
endmodule : identify_word_formatter_tb
